// ### core/perf_event_pkg.sv
// Constants and types shared by the performance-event counting block.
// Assumes a single core clock domain; all event inputs are same-clock logic.
package perf_event_pkg;

  localparam int CNT0_WIDTH     = 16;
  localparam int CNT1_WIDTH     = 16;
  localparam int CNT2_WIDTH     = 14;
  localparam int IRQ_DELAY      = 6;
  localparam int SEL_WIDTH      = 4;
  localparam int GEN_SEL_WIDTH  = 3;

  // Cache/bus unit event selection codes.
  localparam logic [3:0] SEL_READ_HIT      = 4'h0;
  localparam logic [3:0] SEL_READ_REQ      = 4'h1;
  localparam logic [3:0] SEL_DREAD_FILL    = 4'h2;
  localparam logic [3:0] SEL_IREAD_REQ     = 4'h3;
  localparam logic [3:0] SEL_DREAD_REQ     = 4'h4;
  localparam logic [3:0] SEL_WRITE_REQ     = 4'h5;
  localparam logic [3:0] SEL_MISS_FETCH    = 4'h6;
  localparam logic [3:0] SEL_DIRTY_EVICT   = 4'h7;
  localparam logic [3:0] SEL_REFILL        = 4'h8;
  localparam logic [3:0] SEL_PROBE_READ    = 4'h9;
  localparam logic [3:0] SEL_PROBE_FLUSH   = 4'hA;
  localparam logic [3:0] SEL_DREAD_HIT     = 4'hB;

  // General counter input selection codes.
  localparam logic [2:0] GSEL_ISSUE        = 3'h0;
  localparam logic [2:0] GSEL_NONISSUE     = 3'h1;
  localparam logic [2:0] GSEL_CYCLE        = 3'h2;
  localparam logic [2:0] GSEL_PIPE_DRY     = 3'h3;
  localparam logic [2:0] GSEL_PIPE_FREEZE  = 3'h4;
  localparam logic [2:0] GSEL_MISPREDICT   = 3'h5;
  localparam logic [2:0] GSEL_CACHE_MISS   = 3'h6;
  localparam logic [2:0] GSEL_INSN_CLASS   = 3'h7;

  // Translation-unit request types.
  typedef enum logic [1:0] {REQ_NONE, REQ_IREAD, REQ_DREAD, REQ_WRITE} req_type_t;

  localparam logic [15:0] CNT_RESET      = 16'h0000;
  localparam logic [2:0]  OVF_RESET      = 3'h0;

endpackage : perf_event_pkg

// ### core/perf_event_counters.sv
// Three performance counters with event filtering and delayed overflow interrupt.
// Assumes event strobes are single-cycle pulses on ref_clk from on-chip logic.

`timescale 1ns/1ps
`default_nettype none

module perf_event_counters
  import perf_event_pkg::*;
#(
  parameter int W0 = perf_event_pkg::CNT0_WIDTH,
  parameter int W1 = perf_event_pkg::CNT1_WIDTH,
  parameter int W2 = perf_event_pkg::CNT2_WIDTH
)
(
  input  wire logic                               ref_clk,
  input  wire logic                               resetn,
  input  wire logic                               clkEn,
  input  wire logic                               countEnable,
  input  wire logic [perf_event_pkg::SEL_WIDTH-1:0]     sel0,
  input  wire logic [perf_event_pkg::SEL_WIDTH-1:0]     sel1,
  input  wire logic [perf_event_pkg::GEN_SEL_WIDTH-1:0] sel2,
  input  wire logic                               evIssue,
  input  wire logic                               evNonIssue,
  input  wire logic                               evPipeDry,
  input  wire logic                               evPipeFreeze,
  input  wire logic                               evMispredict,
  input  wire logic                               evCacheMiss,
  input  wire logic                               evInsnClass,
  input  wire logic                               reqValid,
  input  wire perf_event_pkg::req_type_t          reqType,
  input  wire logic                               reqIo,
  input  wire logic                               reqHit,
  input  wire logic                               victimValidDirty,
  input  wire logic                               refillValid,
  input  wire logic                               refillIo,
  input  wire logic                               refillForWrite,
  input  wire logic                               ioBlockWrite,
  input  wire logic                               probeRead,
  input  wire logic                               probeFlush,
  input  wire logic                               probeInvalidate,
  input  wire logic [2:0]                         irqClear,
  output logic [W0-1:0]                           count0,
  output logic [W1-1:0]                           count1,
  output logic [W2-1:0]                           count2,
  output logic [2:0]                              irqPending,
  output logic                                    perfIrq,
  output logic                                    missFetchCmd,
  output logic                                    missFetchIo,
  output logic                                    dirtyEvictCmd,
  output logic                                    forwardToCaches,
  output logic                                    mergeWriteData,
  output logic [15:0]                             outstandingFetch
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [W0-1:0]        c0;
    logic [W1-1:0]        c1;
    logic [W2-1:0]        c2;
    logic [2:0]           ovf;
    logic [IRQ_DELAY-1:0] ovfPipe0;
    logic [IRQ_DELAY-1:0] ovfPipe1;
    logic [IRQ_DELAY-1:0] ovfPipe2;
    logic                 irq;
    logic                 mf;
    logic                 mfIo;
    logic                 de;
    logic                 fwd;
    logic                 mrg;
    logic [15:0]          pend;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ==========================================================================
  // Event selection
  // ==========================================================================
  function automatic logic cbuEvent(
    input logic [SEL_WIDTH-1:0] sel,
    input logic                 rdHit,
    input logic                 rdReq,
    input logic                 dFill,
    input logic                 iReq,
    input logic                 dReq,
    input logic                 wReq,
    input logic                 mfc,
    input logic                 dev,
    input logic                 rfl,
    input logic                 pr,
    input logic                 pf,
    input logic                 dHit
  );
    logic r;
    r = 1'b0;
    if (sel == SEL_READ_HIT)         r = rdHit;
    else if (sel == SEL_READ_REQ)    r = rdReq;
    else if (sel == SEL_DREAD_FILL)  r = dFill;
    else if (sel == SEL_IREAD_REQ)   r = iReq;
    else if (sel == SEL_DREAD_REQ)   r = dReq;
    else if (sel == SEL_WRITE_REQ)   r = wReq;
    else if (sel == SEL_MISS_FETCH)  r = mfc;
    else if (sel == SEL_DIRTY_EVICT) r = dev;
    else if (sel == SEL_REFILL)      r = rfl;
    else if (sel == SEL_PROBE_READ)  r = pr;
    else if (sel == SEL_PROBE_FLUSH) r = pf;
    else if (sel == SEL_DREAD_HIT)   r = dHit;
    return r;
  endfunction : cbuEvent

  logic cacheReq;
  logic iRd;
  logic dRd;
  logic wr;
  logic rdAll;
  logic miss;
  logic ev0;
  logic ev1;
  logic ev2;
  logic cntRefill;
  logic cntMissFetch;
  logic cntEvict;
  logic rdHitEv;
  logic dFillEv;
  logic dHitEv;

  always_comb
  begin
    cacheReq     = reqValid && !reqIo;
    iRd          = cacheReq && (reqType == REQ_IREAD);
    dRd          = cacheReq && (reqType == REQ_DREAD);
    wr           = cacheReq && (reqType == REQ_WRITE);
    rdAll        = iRd || dRd;
    miss         = reqValid && (reqType != REQ_NONE) && !reqHit;
    cntMissFetch = miss && !reqIo;
    cntEvict     = miss && !reqIo && victimValidDirty;
    cntRefill    = refillValid && !refillIo;
    rdHitEv      = rdAll && reqHit;
    dFillEv      = dRd && cntRefill;
    dHitEv       = dRd && reqHit;
    // Block writes and probe-invalidates have no selection code at all.
    ev0 = cbuEvent(sel0,
                   rdHitEv,
                   rdAll,
                   dFillEv,
                   iRd,
                   dRd,
                   wr,
                   cntMissFetch,
                   cntEvict,
                   cntRefill,
                   probeRead,
                   probeFlush,
                   dHitEv);
    ev1 = cbuEvent(sel1,
                   rdHitEv,
                   rdAll,
                   dFillEv,
                   iRd,
                   dRd,
                   wr,
                   cntMissFetch,
                   cntEvict,
                   cntRefill,
                   probeRead,
                   probeFlush,
                   dHitEv);
    case (sel2)
      GSEL_ISSUE:       ev2 = evIssue;
      GSEL_NONISSUE:    ev2 = evNonIssue;
      GSEL_CYCLE:       ev2 = 1'b1;
      GSEL_PIPE_DRY:    ev2 = evPipeDry;
      GSEL_PIPE_FREEZE: ev2 = evPipeFreeze;
      GSEL_MISPREDICT:  ev2 = evMispredict;
      GSEL_CACHE_MISS:  ev2 = evCacheMiss;
      default:          ev2 = evInsnClass;
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic [2:0] wrapNow;
  logic [2:0] ovfArrive;

  always_comb
  begin
    next_cur = cur;
    // A wrap is taken from the all-ones value so the pipe starts on the event.
    wrapNow  = 3'h0;
    if (countEnable && ev0)
    begin
      wrapNow[0]  = &cur.c0;
      next_cur.c0 = cur.c0 + W0'(1);
    end
    if (countEnable && ev1)
    begin
      wrapNow[1]  = &cur.c1;
      next_cur.c1 = cur.c1 + W1'(1);
    end
    if (countEnable && ev2)
    begin
      wrapNow[2]  = &cur.c2;
      next_cur.c2 = cur.c2 + W2'(1);
    end
    // The overflow travels six stages so the interrupt lags the event.
    next_cur.ovfPipe0 = {cur.ovfPipe0[IRQ_DELAY-2:0], wrapNow[0]};
    next_cur.ovfPipe1 = {cur.ovfPipe1[IRQ_DELAY-2:0], wrapNow[1]};
    next_cur.ovfPipe2 = {cur.ovfPipe2[IRQ_DELAY-2:0], wrapNow[2]};
    ovfArrive[0] = cur.ovfPipe0[IRQ_DELAY-1];
    ovfArrive[1] = cur.ovfPipe1[IRQ_DELAY-1];
    ovfArrive[2] = cur.ovfPipe2[IRQ_DELAY-1];
    // An arriving overflow wins over a clear in the same cycle.
    next_cur.ovf = ovfArrive | (cur.ovf & ~irqClear);
    next_cur.irq = |next_cur.ovf;

    // Miss handling: a miss fetches, a dirty victim of a non-I/O miss is also evicted.
    // Same-type merged misses arrive here as one request.
    next_cur.mf   = miss;
    next_cur.mfIo = miss && reqIo;
    next_cur.de   = miss && !reqIo && victimValidDirty;
    next_cur.fwd = refillValid && !refillForWrite;
    next_cur.mrg = refillValid && refillForWrite;
    // A miss and a refill in one cycle cancel, so the count stands.
    // The decrement stops at zero so a stray refill cannot wrap it.
    if (miss && !refillValid)
    begin
      next_cur.pend = cur.pend + 16'h0001;
    end
    else if (!miss && refillValid && (cur.pend != 16'h0000))
    begin
      next_cur.pend = cur.pend - 16'h0001;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      cur              <= '0;
      cur.c0           <= CNT_RESET[W0-1:0];
      cur.c1           <= CNT_RESET[W1-1:0];
      cur.c2           <= CNT_RESET[W2-1:0];
      cur.ovf          <= OVF_RESET;
    end
    else if (clkEn)
    begin
      // A low enable freezes the counters and the delay pipe alike.
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign count0           = cur.c0;
  assign count1           = cur.c1;
  assign count2           = cur.c2;
  assign irqPending       = cur.ovf;
  assign perfIrq          = cur.irq;
  assign missFetchCmd     = cur.mf;
  assign missFetchIo      = cur.mfIo;
  assign dirtyEvictCmd    = cur.de;
  assign forwardToCaches  = cur.fwd;
  assign mergeWriteData   = cur.mrg;
  assign outstandingFetch = cur.pend;

endmodule : perf_event_counters

`default_nettype wire

// ### verification/perf_checker.sv
// Port-level assertions for the performance-event counter block.
// Assumes one clock domain, ref_clk, with synchronous active-low resetn.
`timescale 1ns/1ps
`default_nettype none

module perf_checker
  import perf_event_pkg::*;
#(
  parameter int W0 = CNT0_WIDTH,
  parameter int W2 = CNT2_WIDTH
)
(
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic                 clkEn,
  input wire logic                 countEnable,
  input wire logic [SEL_WIDTH-1:0] sel0,
  input wire logic                 reqValid,
  input wire req_type_t            reqType,
  input wire logic                 reqIo,
  input wire logic                 reqHit,
  input wire logic                 victimValidDirty,
  input wire logic                 refillValid,
  input wire logic                 refillIo,
  input wire logic                 refillForWrite,
  input wire logic [2:0]           irqClear,
  input wire logic [W0-1:0]        count0,
  input wire logic [2:0]           irqPending,
  input wire logic                 perfIrq,
  input wire logic                 missFetchCmd,
  input wire logic                 missFetchIo,
  input wire logic                 dirtyEvictCmd,
  input wire logic                 forwardToCaches,
  input wire logic                 mergeWriteData
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic miss;
  logic fill;
  assign miss = clkEn && reqValid && reqType != REQ_NONE && !reqHit && !reqIo;
  assign fill = clkEn && refillValid && !refillIo;

  miss_fetch_a: assert property (miss |=> missFetchCmd)
    else $error("miss-fetch not issued");
  io_fetch_a: assert property (clkEn && reqValid && reqType != REQ_NONE && !reqHit && reqIo |=> missFetchCmd && missFetchIo)
    else $error("I/O miss-fetch not marked");
  dirty_evict_a: assert property (miss && victimValidDirty |=> dirtyEvictCmd)
    else $error("dirty eviction not issued");
  fill_forward_a: assert property (fill && !refillForWrite |=> forwardToCaches)
    else $error("refill data not forwarded");
  fill_merge_a: assert property (fill && refillForWrite |=> mergeWriteData)
    else $error("write data not merged");
  irq_delay_a: assert property ($past(count0) == {W0{1'b1}} && count0 == '0 && clkEn ##1 clkEn [*5] |=> irqPending[0])
    else $error("overflow flag late");
  irq_summary_a: assert property (perfIrq == |irqPending)
    else $error("interrupt differs from flags");
  flag_sticky_a: assert property (irqPending[2] && !irqClear[2] |=> irqPending[2])
    else $error("overflow flag dropped");
  write_filter_a: assert property (clkEn && sel0 == SEL_WRITE_REQ && !(reqValid && reqType == REQ_WRITE && !reqIo) |=> $stable(count0))
    else $error("write count moved");
  read_sum_a: assert property (clkEn && countEnable && sel0 == SEL_READ_REQ && reqValid && !reqIo && (reqType == REQ_IREAD || reqType == REQ_DREAD) |=> count0 == $past(count0) + 1'b1)
    else $error("read total missed");
endmodule : perf_checker

bind perf_event_counters perf_checker #(.W0(W0), .W2(W2)) chk_u (.*);

`default_nettype wire

// ### verification/perf_partner.sv
// System-side model that answers each miss-fetch with one refill.
// Assumes at most one miss-fetch outstanding; lag sets the answer delay.
`timescale 1ns/1ps
`default_nettype none

module perf_partner
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       missFetchCmd,
  input  wire logic       missFetchIo,
  input  wire logic [3:0] lag,
  output logic            refillValid,
  output logic            refillIo
);
  logic [3:0] waitCnt;
  logic       busy;
  logic       ioSeen;
  always_ff @(posedge ref_clk)
  begin
    refillValid <= 1'b0;
    refillIo <= ~refillIo;
    if (!resetn)
    begin
      busy <= 1'b0;
      refillIo <= 1'b0;
    end
    else if (missFetchCmd)
    begin
      busy <= 1'b1;
      waitCnt <= lag;
      ioSeen <= missFetchIo;
    end
    else if (busy && waitCnt != 4'h0)
      waitCnt <= waitCnt - 4'h1;
    else if (busy)
    begin
      busy <= 1'b0;
      refillValid <= 1'b1;
      refillIo <= ioSeen;
    end
  end
endmodule : perf_partner

`default_nettype wire

// ### verification/perf_event_counters_bench.sv
// Self-checking bench for the performance-event counter block.
// Assumes the partner model answers miss-fetches; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none

module perf_event_counters_bench;
  import perf_event_pkg::*;
  logic ref_clk, resetn = 1'b0, clkEn = 1'b1, countEnable = 1'b1;
  logic [3:0] sel0 = 4'h0, sel1 = 4'h0, lag = 4'h0;
  logic [2:0] sel2 = 3'h0, irqClear = 3'h0, irqPending;
  logic [7:0] ev = 8'h00;
  logic reqValid = 1'b0, reqIo = 1'b0, reqHit = 1'b0, victimValidDirty = 1'b0;
  logic refillForWrite = 1'b0, ioBlockWrite = 1'b0, probeRead = 1'b0;
  logic probeFlush = 1'b0, probeInvalidate = 1'b0;
  req_type_t reqType = REQ_NONE;
  logic [15:0] count0, count1, outstandingFetch;
  logic [13:0] count2;
  logic perfIrq, missFetchCmd, missFetchIo, dirtyEvictCmd, forwardToCaches;
  logic mergeWriteData, refillValid, refillIo;
  wire evIssue, evNonIssue, evPipeDry, evPipeFreeze, evMispredict, evCacheMiss, evInsnClass;
  int failures = 0, checks_done = 0;
  assign {evInsnClass, evCacheMiss, evMispredict, evPipeFreeze, evPipeDry} = ev[7:3];
  assign {evNonIssue, evIssue} = ev[1:0];

  perf_event_counters dut_u (.*);
  perf_partner sys_u (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic pulse(ref logic s);
    @(negedge ref_clk) s = 1'b1;
    @(negedge ref_clk) s = 1'b0;
  endtask : pulse

  task automatic req(input req_type_t t, input logic io, input logic hit, input logic vd);
    reqType = t;
    reqIo = io;
    reqHit = hit;
    victimValidDirty = vd;
    pulse(reqValid);
    repeat (14) @(negedge ref_clk);
  endtask : req

  // ==========================================================
  // Scenarios
  task automatic t_reqs();
    logic [15:0] c0, c1;
    @(negedge ref_clk);
    {sel0, sel1, c0, c1} = {SEL_WRITE_REQ, SEL_READ_REQ, count0, count1};
    req(REQ_IREAD, 1'b0, 1'b1, 1'b0);
    req(REQ_DREAD, 1'b0, 1'b1, 1'b0);
    req(REQ_WRITE, 1'b0, 1'b1, 1'b0);
    req(REQ_DREAD, 1'b1, 1'b0, 1'b0);
    req(REQ_WRITE, 1'b1, 1'b1, 1'b0);
    check(count0, c0 + 16'h1);
    check(count1, c1 + 16'h2);
  endtask : t_reqs

  task automatic t_miss();
    logic [15:0] c0, c1;
    @(negedge ref_clk);
    {sel0, sel1, c0, c1} = {SEL_MISS_FETCH, SEL_DIRTY_EVICT, count0, count1};
    req(REQ_DREAD, 1'b0, 1'b0, 1'b1);
    pulse(ioBlockWrite);
    req(REQ_IREAD, 1'b1, 1'b0, 1'b1);
    check(count0, c0 + 16'h1);
    check(count1, c1 + 16'h1);
    check(outstandingFetch, 16'h0);
  endtask : t_miss

  task automatic t_fill();
    logic [15:0] c0, c1;
    @(negedge ref_clk);
    {sel0, sel1, lag, c0, c1} = {SEL_REFILL, SEL_PROBE_READ, 4'h9, count0, count1};
    refillForWrite = 1'b1;
    req(REQ_WRITE, 1'b0, 1'b0, 1'b0);
    refillForWrite = 1'b0;
    req(REQ_DREAD, 1'b0, 1'b0, 1'b0);
    req(REQ_DREAD, 1'b1, 1'b0, 1'b0);
    pulse(probeRead);
    pulse(probeInvalidate);
    sel1 = SEL_PROBE_FLUSH;
    pulse(probeFlush);
    pulse(probeInvalidate);
    check(count0, c0 + 16'h2);
    check(outstandingFetch, 16'h0);
    check(count1, c1 + 16'h2);
  endtask : t_fill

  task automatic t_gen();
    logic [13:0] c2;
    for (int k = 0; k < 8; k++)
    begin
      @(negedge ref_clk);
      {sel2, c2, countEnable, ev} = {k[2:0], count2, 1'b1, ~(8'h1 << k)};
      @(negedge ref_clk) ev = 8'h1 << k;
      @(negedge ref_clk) {ev, countEnable} = 9'h0;
      @(negedge ref_clk) check({2'b0, count2}, {2'b0, c2 + ((k == 2) ? 14'h2 : 14'h1)});
    end
    countEnable = 1'b1;
  endtask : t_gen

  task automatic t_wrap();
    int z0 = -1, z2 = -1;
    logic d0 = 1'b0, d2 = 1'b0;
    @(negedge ref_clk);
    {sel0, sel2} = {SEL_READ_REQ, GSEL_CYCLE};
    reqType = REQ_IREAD;
    {reqIo, reqHit} = 2'b01;
    reqValid = 1'b1;
    for (int i = 0; i < 70000 && !(d0 && d2); i++)
    begin
      @(negedge ref_clk);
      z0 = (z0 >= 0) ? z0 + 1 : ((count0 == 16'h0) ? 0 : -1);
      z2 = (z2 >= 0) ? z2 + 1 : ((count2 == 14'h0) ? 0 : -1);
      if (irqPending[0] && !d0)
        check(16'(z0), 16'h6);
      if (irqPending[0])
        d0 = 1'b1;
      if (irqPending[2] && !d2)
        check(16'(z2), 16'h6);
      if (irqPending[2])
        {d2, sel2} = {1'b1, GSEL_ISSUE};
    end
    reqValid = 1'b0;
    check({15'h0, d0}, 16'h1);
    check({13'h0, irqPending}, 16'h5);
    @(negedge ref_clk) irqClear = 3'b101;
    @(negedge ref_clk) irqClear = 3'b000;
    check({12'h0, perfIrq, irqPending}, 16'h0);
  endtask : t_wrap

  initial
  begin
    repeat (8) @(negedge ref_clk);
    check(count0 | count1, 16'h0);
    check({2'b0, count2}, 16'h0);
    resetn = 1'b1;
    t_reqs();
    t_miss();
    t_fill();
    t_gen();
    t_wrap();
    test_done();
  end

  initial
  begin
    #(80000 * 8);
    failures++;
    test_done();
  end
endmodule : perf_event_counters_bench

`default_nettype wire
